// file: design/tss_cfg.svh
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define TSS_ADDR_TEMP_MSB 8'hAA
`define TSS_ADDR_TEMP_LSB 8'hAB
`define TSS_ADDR_CFG_MSB 8'hAC
`define TSS_ADDR_CFG_LSB 8'hAD
`define TSS_ADDR_LAST 8'hAD
`define TSS_ADDR_UNDEF0 8'hA8
`define TSS_ADDR_UNDEF1 8'hA9
`define TSS_ADDR_FIRST 8'hA0
`define TSS_READ_PAST 8'hFF

// ----------------------------------------
// configuration fields (msb byte at ACh)
// ----------------------------------------
`define TSS_CFG_DONE_BIT 7
`define TSS_CFG_NVB_BIT 6
`define TSS_CFG_RES_HI_BIT 3
`define TSS_CFG_RES_LO_BIT 2
`define TSS_CFG_SINGLE_BIT 0
// lsb byte at ADh
`define TSS_CFG_FORCE_BIT 7
`define TSS_CFG_POL_BIT 6
`define TSS_CFG_APIN_HI_BIT 5
`define TSS_CFG_APIN_MID_BIT 4
`define TSS_CFG_APIN_LO_BIT 3
`define TSS_CFG_MSB_RESET 8'h8C
`define TSS_CFG_LSB_RESET 8'h80

// ----------------------------------------
// slave address and commands
// ----------------------------------------
`define TSS_SLAVE_FIXED 4'h9
`define TSS_CMD_START_CONV 8'h51
`define TSS_CMD_STOP_CONV 8'h22
`define TSS_CMD_RECALL 8'hB8
`define TSS_CMD_COPY 8'h48
`define TSS_CMD_SOFT_POR 8'h54

// ----------------------------------------
// timing
// ----------------------------------------
`define TSS_CLK_MHZ 10
`define TSS_CONV_10B_MS 25
`define TSS_CONV_11B_MS 50
`define TSS_CONV_12B_MS 100
`define TSS_CONV_13B_MS 200
`define TSS_CYC_PER_MS (`TSS_CLK_MHZ * 1000)
`define TSS_NV_WRITE_CYC 32'd1000

`endif

// file: design/tss_pkg.sv
package tss_pkg;
    typedef enum logic [1:0] {
        TSS_RES_10 = 2'b00,
        TSS_RES_11 = 2'b01,
        TSS_RES_12 = 2'b10,
        TSS_RES_13 = 2'b11
    } tss_res_type;

    typedef enum logic [2:0] {
        TSS_ST_IDLE = 3'b000,
        TSS_ST_CTRL = 3'b001,
        TSS_ST_ADDR = 3'b010,
        TSS_ST_WDATA = 3'b011,
        TSS_ST_RDATA = 3'b100,
        TSS_ST_IGNORE = 3'b101
    } tss_state_type;
endpackage : tss_pkg

// file: design/tss_sync2.sv
`timescale 1ns/100ps
// two-stage synchroniser; first stage feeds only the second
module tss_sync2 (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_reg <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule : tss_sync2

// file: design/tss_conv_timer.sv
`timescale 1ns/100ps
`include "tss_cfg.svh"
// counts one conversion of the length chosen by the resolution select
module tss_conv_timer
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic start_in,
    input wire logic abort_in,
    input tss_pkg::tss_res_type res_in,
    // status
    output logic busy_out,
    output logic done_out
);
    import tss_pkg::*;
    localparam int unsigned CYC10 = `TSS_CONV_10B_MS * `TSS_CYC_PER_MS;
    localparam int unsigned CYC11 = `TSS_CONV_11B_MS * `TSS_CYC_PER_MS;
    localparam int unsigned CYC12 = `TSS_CONV_12B_MS * `TSS_CYC_PER_MS;
    localparam int unsigned CYC13 = `TSS_CONV_13B_MS * `TSS_CYC_PER_MS;

    logic [31:0] count_reg;
    logic [31:0] len;

    always_comb begin
        case (res_in)
            TSS_RES_10: len = CYC10;
            TSS_RES_11: len = CYC11;
            TSS_RES_12: len = CYC12;
            default: len = CYC13;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || abort_in) begin
            count_reg <= 32'h0000_0000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in && !busy_out) begin
            count_reg <= len - 32'h0000_0001;
            busy_out <= 1'b1;
            done_out <= 1'b0;
        end else if (busy_out) begin
            done_out <= 1'b0;
            if (count_reg == 32'h0000_0000) begin
                busy_out <= 1'b0;
                done_out <= 1'b1;
            end else begin
                count_reg <= count_reg - 32'h0000_0001;
            end
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule : tss_conv_timer

// file: design/tss_top.sv
`timescale 1ns/100ps
`include "tss_cfg.svh"
// Contract
// - force bit 0 drives the programmable output low.
// - force bit 1 gives thermostat output with selected polarity.
// - force bit resets to 1, thermostat mode.
// - three read-only config bits show the address pins.
// - resolution select picks 10 to 13 bits, 25 to 200 ms.
// - bytes shift msb first, one bit per serial clock.
// - answer only to address 1001 plus the address pins.
// - control byte is address in 7:1, direction in bit 0.
// - receiver pulls data low for the ninth clock as acknowledge.
// - data changes with clock low; start and stop with clock high.
// - acknowledge matching write control byte and following byte.
// - first write byte loads counter; later bytes stored, counter increments.
// - past ADh writes nacked and dropped; A8h, A9h writes ignored.
// - writes reach shadow only; copy stores all but temperature, undefined.
// - read is address write, restart, control read, device sends data.
// - reads past ADh return FFh.
// - 51h starts conversion, single or continuous.
// - 22h stops continuous conversion, ignored in single mode.
// - B8h reloads shadow from nonvolatile storage.
// - 48h copies shadow to nonvolatile storage.
// - 54h stops conversion and resets shadow and serial link; nonvolatile store and its busy flag are kept.
// - conversion-complete flag is 0 while converting, 1 when done.
// - nonvolatile busy flag is 1 while writing, 0 at power-up.
module tss_top
(
    // core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // serial link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // address pins
    input wire logic addr_pin_hi_in,
    input wire logic addr_pin_mid_in,
    input wire logic addr_pin_lo_in,
    // thermostat and programmable output
    input wire logic thermostat_trip_in,
    input wire logic [15:0] temperature_in,
    output logic programmable_output_pin_out,
    output logic programmable_output_pin_oe_out,
    // status
    output logic converting_out,
    output logic nonvolatile_busy_flag_out
);
    import tss_pkg::*;

    // ----------------------------------------
    // link domain: bit engine on scl edges
    // ----------------------------------------
    // start/stop are async sda edges while scl high; flags reach the scl-domain bit engine by toggles
    logic start_tgl_reg;
    logic stop_tgl_reg;
    logic soft_por_core;
    logic link_rst_n;
    assign link_rst_n = rst_n_in & ~soft_por_core;
    // start/stop detectors run on sda edges, scl sampled as data
    always_ff @(negedge sda_in) begin
        if (!link_rst_n) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end
    always_ff @(posedge sda_in) begin
        if (!link_rst_n) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end
    // scl-domain copy of start toggle, so the bit engine sees a start
    logic start_seen_reg;
    logic stop_seen_reg;
    tss_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] addr_cnt_reg;
    logic [7:0] rd_byte;
    logic ack_ok_reg;
    logic read_dir_reg;
    logic link_write_tgl_reg;
    logic [7:0] link_wdata_reg;
    logic [7:0] link_waddr_reg;
    logic link_cmd_tgl_reg;
    logic [7:0] link_cmd_reg;
    logic sda_drive_low_reg;
    logic [7:0] shadow_mem [0:13];
    logic [2:0] apins_link;
    logic [7:0] rx_byte;
    assign rx_byte = {shift_reg[6:0], sda_in};
    // bit counter and receive shifter sample on scl rising edge
    always_ff @(posedge scl_in) begin
        if (!link_rst_n) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
            state_reg <= TSS_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            addr_cnt_reg <= 8'h00;
            ack_ok_reg <= 1'b0;
            read_dir_reg <= 1'b0;
            link_write_tgl_reg <= 1'b0;
            link_wdata_reg <= 8'h00;
            link_waddr_reg <= 8'h00;
            link_cmd_tgl_reg <= 1'b0;
            link_cmd_reg <= 8'h00;
        end else if (start_seen_reg != start_tgl_reg) begin
            // first scl rise after start is bit 7 of control byte
            start_seen_reg <= start_tgl_reg;
            stop_seen_reg <= stop_tgl_reg;
            state_reg <= TSS_ST_CTRL;
            bit_cnt_reg <= 4'h1;
            shift_reg <= {7'h00, sda_in};
        end else if (stop_seen_reg != stop_tgl_reg) begin
            stop_seen_reg <= stop_tgl_reg;
            state_reg <= TSS_ST_IDLE;
        end else if (bit_cnt_reg == 4'h8) begin
            // ninth clock: acknowledge slot
            bit_cnt_reg <= 4'h0;
            if (state_reg == TSS_ST_RDATA && sda_in) begin
                state_reg <= TSS_ST_IGNORE;
            end
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= rx_byte;
            if (bit_cnt_reg == 4'h7) begin
                case (state_reg)
                    TSS_ST_CTRL: begin
                        if (rx_byte[7:1] == {`TSS_SLAVE_FIXED, apins_link}) begin
                            read_dir_reg <= rx_byte[0];
                            state_reg <= rx_byte[0] ? TSS_ST_RDATA : TSS_ST_ADDR;
                            ack_ok_reg <= 1'b1;
                        end else begin
                            state_reg <= TSS_ST_IGNORE;
                            ack_ok_reg <= 1'b0;
                        end
                    end
                    TSS_ST_ADDR: begin
                        addr_cnt_reg <= rx_byte;
                        link_cmd_reg <= rx_byte;
                        link_cmd_tgl_reg <= ~link_cmd_tgl_reg;
                        state_reg <= TSS_ST_WDATA;
                        ack_ok_reg <= 1'b1;
                    end
                    TSS_ST_WDATA: begin
                        ack_ok_reg <= (addr_cnt_reg <= `TSS_ADDR_LAST);
                        if (addr_cnt_reg <= `TSS_ADDR_LAST) begin
                            link_wdata_reg <= rx_byte;
                            link_waddr_reg <= addr_cnt_reg;
                            link_write_tgl_reg <= ~link_write_tgl_reg;
                            addr_cnt_reg <= addr_cnt_reg + 8'h01;
                        end
                    end
                    TSS_ST_RDATA: begin
                        ack_ok_reg <= 1'b0;
                        addr_cnt_reg <= addr_cnt_reg + 8'h01;
                    end
                    default: ack_ok_reg <= 1'b0;
                endcase
            end
        end
    end
    // read data: shadow, or all ones outside the map (below A0h or past ADh)
    always_comb begin
        if (addr_cnt_reg > `TSS_ADDR_LAST || addr_cnt_reg < `TSS_ADDR_FIRST) begin
            rd_byte = `TSS_READ_PAST;
        end else begin
            rd_byte = shadow_mem[4'(addr_cnt_reg - `TSS_ADDR_FIRST)];
        end
    end
    // sda driven on scl falling edge so it only changes with scl low
    logic [7:0] tx_shift_reg;
    always_ff @(negedge scl_in) begin
        if (!link_rst_n) begin
            sda_drive_low_reg <= 1'b0;
            tx_shift_reg <= 8'hFF;
        end else if (state_reg == TSS_ST_IDLE || state_reg == TSS_ST_IGNORE) begin
            sda_drive_low_reg <= 1'b0;
        end else if (bit_cnt_reg == 4'h8) begin
            if (state_reg == TSS_ST_RDATA && !read_dir_reg) begin
                sda_drive_low_reg <= 1'b0;
            end else if (state_reg == TSS_ST_RDATA && !ack_ok_reg) begin
                sda_drive_low_reg <= 1'b0; // master acks, we release
            end else begin
                sda_drive_low_reg <= ack_ok_reg;
            end
        end else if (state_reg == TSS_ST_RDATA) begin
            if (bit_cnt_reg == 4'h0) begin
                tx_shift_reg <= {rd_byte[6:0], 1'b1};
                sda_drive_low_reg <= ~rd_byte[7];
            end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                sda_drive_low_reg <= ~tx_shift_reg[7];
            end
        end else begin
            sda_drive_low_reg <= 1'b0;
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_drive_low_reg;

    // ----------------------------------------
    // crossings into core domain
    // ----------------------------------------
    logic wr_tgl_s;
    logic cmd_tgl_s;
    logic wr_tgl_d_reg;
    logic cmd_tgl_d_reg;
    logic apin_hi_s;
    logic apin_mid_s;
    logic apin_lo_s;
    logic trip_s;
    tss_sync2 u_sync_wr (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .d_in(link_write_tgl_reg), .q_out(wr_tgl_s));
    tss_sync2 u_sync_cmd (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .d_in(link_cmd_tgl_reg), .q_out(cmd_tgl_s));
    tss_sync2 u_sync_a2 (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .d_in(addr_pin_hi_in), .q_out(apin_hi_s));
    tss_sync2 u_sync_a1 (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .d_in(addr_pin_mid_in), .q_out(apin_mid_s));
    tss_sync2 u_sync_a0 (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .d_in(addr_pin_lo_in), .q_out(apin_lo_s));
    tss_sync2 u_sync_trip (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .d_in(thermostat_trip_in), .q_out(trip_s));
    // address pins are straps: scl-side match uses the synchronised copy, static in practice
    assign apins_link = {apin_hi_s, apin_mid_s, apin_lo_s};
    logic wr_pulse;
    logic cmd_pulse;
    assign wr_pulse = wr_tgl_s ^ wr_tgl_d_reg;
    assign cmd_pulse = cmd_tgl_s ^ cmd_tgl_d_reg;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_tgl_d_reg <= 1'b0;
            cmd_tgl_d_reg <= 1'b0;
        end else begin
            wr_tgl_d_reg <= wr_tgl_s;
            cmd_tgl_d_reg <= cmd_tgl_s;
        end
    end

    // ----------------------------------------
    // core: shadow, nonvolatile copy, commands
    // ----------------------------------------
    // link data regs are stable for many core cycles after each toggle
    logic [7:0] nv_mem [0:13];
    logic conv_run_reg;
    logic continuous_reg;
    logic nv_busy_reg;
    logic [31:0] nv_cnt_reg;
    logic conv_busy;
    logic conv_done;
    logic soft_por_reg;
    logic [3:0] widx;
    logic [7:0] cfg_msb;
    logic [7:0] cfg_lsb;
    assign soft_por_core = soft_por_reg;
    assign widx = 4'(link_waddr_reg - `TSS_ADDR_FIRST);
    assign cfg_msb = shadow_mem[4'(`TSS_ADDR_CFG_MSB - `TSS_ADDR_FIRST)];
    assign cfg_lsb = shadow_mem[4'(`TSS_ADDR_CFG_LSB - `TSS_ADDR_FIRST)];
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || soft_por_reg) begin
            for (int i = 0; i < 14; i++) begin
                shadow_mem[i] <= 8'h00;
            end
            shadow_mem[12] <= `TSS_CFG_MSB_RESET;
            shadow_mem[13] <= `TSS_CFG_LSB_RESET;
        end else begin
            if (wr_pulse && link_waddr_reg >= `TSS_ADDR_FIRST
                && link_waddr_reg != `TSS_ADDR_UNDEF0
                && link_waddr_reg != `TSS_ADDR_UNDEF1
                && link_waddr_reg != `TSS_ADDR_TEMP_MSB
                && link_waddr_reg != `TSS_ADDR_TEMP_LSB) begin
                shadow_mem[widx] <= link_wdata_reg;
            end else if (cmd_pulse && link_cmd_reg == `TSS_CMD_RECALL) begin
                for (int i = 0; i < 10; i++) begin
                    shadow_mem[i] <= nv_mem[i];
                end
                shadow_mem[12] <= nv_mem[12];
                shadow_mem[13] <= nv_mem[13];
            end
            shadow_mem[10] <= temperature_in[15:8];
            shadow_mem[11] <= temperature_in[7:0];
            shadow_mem[12][`TSS_CFG_DONE_BIT] <= ~conv_busy;
            shadow_mem[12][`TSS_CFG_NVB_BIT] <= nv_busy_reg;
            shadow_mem[13][`TSS_CFG_APIN_HI_BIT] <= apin_hi_s;
            shadow_mem[13][`TSS_CFG_APIN_MID_BIT] <= apin_mid_s;
            shadow_mem[13][`TSS_CFG_APIN_LO_BIT] <= apin_lo_s;
        end
    end
    // nonvolatile copy; power cycles keep it, so only the rst pin clears it to zero
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 14; i++) begin
                nv_mem[i] <= 8'h00;
            end
            nv_busy_reg <= 1'b0;
            nv_cnt_reg <= 32'h0000_0000;
        end else if (cmd_pulse && link_cmd_reg == `TSS_CMD_COPY && !nv_busy_reg) begin
            for (int i = 0; i < 14; i++) begin
                if (i != 8 && i != 9 && i != 10 && i != 11) begin
                    nv_mem[i] <= shadow_mem[i];
                end
            end
            nv_busy_reg <= 1'b1;
            nv_cnt_reg <= `TSS_NV_WRITE_CYC;
        end else if (nv_busy_reg) begin
            if (nv_cnt_reg == 32'h0000_0000) begin
                nv_busy_reg <= 1'b0;
            end else begin
                nv_cnt_reg <= nv_cnt_reg - 32'h0000_0001;
            end
        end
    end
    // conversion control
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || soft_por_reg) begin
            conv_run_reg <= 1'b0;
            continuous_reg <= 1'b0;
            soft_por_reg <= 1'b0;
        end else begin
            soft_por_reg <= cmd_pulse && link_cmd_reg == `TSS_CMD_SOFT_POR;
            if (cmd_pulse && link_cmd_reg == `TSS_CMD_START_CONV) begin
                conv_run_reg <= 1'b1;
                continuous_reg <= ~cfg_msb[`TSS_CFG_SINGLE_BIT];
            end else if (cmd_pulse && link_cmd_reg == `TSS_CMD_STOP_CONV && continuous_reg) begin
                continuous_reg <= 1'b0;
                conv_run_reg <= 1'b0;
            end else if (conv_done && !continuous_reg) begin
                conv_run_reg <= 1'b0;
            end
        end
    end
    tss_conv_timer u_conv (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(conv_run_reg && !conv_done),
        .abort_in(soft_por_reg || !conv_run_reg),
        .res_in(tss_res_type'({cfg_msb[`TSS_CFG_RES_HI_BIT], cfg_msb[`TSS_CFG_RES_LO_BIT]})),
        .busy_out(conv_busy),
        .done_out(conv_done)
    );
    // programmable output: open drain, low = drive
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            programmable_output_pin_out <= 1'b0;
            programmable_output_pin_oe_out <= 1'b0;
            converting_out <= 1'b0;
            nonvolatile_busy_flag_out <= 1'b0;
        end else begin
            programmable_output_pin_out <= 1'b0;
            if (!cfg_lsb[`TSS_CFG_FORCE_BIT]) begin
                programmable_output_pin_oe_out <= 1'b1;
            end else begin
                programmable_output_pin_oe_out <= trip_s ^ cfg_lsb[`TSS_CFG_POL_BIT];
            end
            converting_out <= conv_busy;
            nonvolatile_busy_flag_out <= nv_busy_reg;
        end
    end
endmodule : tss_top

// file: tb/tss_bus_master.sv
`timescale 1ns/100ps
// ----
// bus master model
// ----
module tss_bus_master (
    // serial link
    output logic scl_out,
    output logic pull_out,
    input wire logic sda_in
);
    initial begin
        scl_out = 1'b1;
        pull_out = 1'b0;
    end
    // data moves only while scl is low; 6 ns bit period
    task automatic put(input logic b, output logic s);
        #1 pull_out = ~b;
        #2 scl_out = 1'b1;
        #1 s = sda_in;
        #2 scl_out = 1'b0;
    endtask : put
    task automatic start;
        #1 pull_out = 1'b0;
        #2 scl_out = 1'b1;
        #3 pull_out = 1'b1;
        #3 scl_out = 1'b0;
    endtask : start
    task automatic stop;
        #1 pull_out = 1'b1;
        #2 scl_out = 1'b1;
        #3 pull_out = 1'b0;
    endtask : stop
    // a=1 releases the ninth bit; scl held low after it so the core side catches up
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
            output logic s);
        for (int i = 7; i >= 0; i--) begin
            put(d[i], q[i]);
        end
        put(a, s);
        #2000;
    endtask : xfer
endmodule : tss_bus_master

// file: tb/tss_chk.sv
`timescale 1ns/100ps
`include "tss_cfg.svh"
module tss_chk (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // watched outputs
    input wire logic sda_out,
    input wire logic thermostat_trip_in,
    input wire logic programmable_output_pin_out,
    input wire logic programmable_output_pin_oe_out,
    input wire logic converting_out,
    input wire logic nonvolatile_busy_flag_out
);
    localparam int NV_LO = `TSS_NV_WRITE_CYC - 4;
    localparam int NV_HI = `TSS_NV_WRITE_CYC + 4;
    logic [15:0] nv_cnt_reg;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // counts busy cycles; a stuck flag shows as an overrun
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || !nonvolatile_busy_flag_out) begin
            nv_cnt_reg <= 16'h0000;
        end else begin
            nv_cnt_reg <= nv_cnt_reg + 16'h0001;
        end
    end
    property p_sda_val; sda_out == 1'b0; endproperty
    a_sda_val: assert property (p_sda_val) else $error("data value not low");
    property p_pin_val; programmable_output_pin_out == 1'b0; endproperty
    a_pin_val: assert property (p_pin_val) else $error("pin value not low");
    property p_rst_flags; $rose(rst_n_in) |-> !converting_out && !nonvolatile_busy_flag_out;
    endproperty
    a_rst_flags: assert property (p_rst_flags) else $error("flags set at reset");
    property p_rst_trip;
        $rose(rst_n_in) ##1 $stable(thermostat_trip_in)[*6]
            |-> programmable_output_pin_oe_out == thermostat_trip_in;
    endproperty
    a_rst_trip: assert property (p_rst_trip) else $error("pin not thermostat");
    property p_conv_min; $rose(converting_out) |=> converting_out[*8]; endproperty
    a_conv_min: assert property (p_conv_min) else $error("conversion cut short");
    property p_nv_held; $rose(nonvolatile_busy_flag_out) |=> nonvolatile_busy_flag_out[*8];
    endproperty
    a_nv_held: assert property (p_nv_held) else $error("busy flag dropped");
    property p_nv_len;
        $fell(nonvolatile_busy_flag_out) |-> nv_cnt_reg inside {[NV_LO:NV_HI]};
    endproperty
    a_nv_len: assert property (p_nv_len) else $error("store time wrong");
    property p_nv_max; nv_cnt_reg <= NV_HI; endproperty
    a_nv_max: assert property (p_nv_max) else $error("busy flag stuck");
    c_conv: cover property ($rose(converting_out));
    c_nv: cover property ($fell(nonvolatile_busy_flag_out));
    c_pin: cover property ($rose(programmable_output_pin_oe_out));
endmodule : tss_chk
bind tss_top tss_chk u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .sda_out(sda_out), .thermostat_trip_in(thermostat_trip_in),
    .programmable_output_pin_out(programmable_output_pin_out),
    .programmable_output_pin_oe_out(programmable_output_pin_oe_out),
    .converting_out(converting_out), .nonvolatile_busy_flag_out(nonvolatile_busy_flag_out));

// file: tb/test_thermometer_serial_slave.sv
`timescale 1ns/100ps
`include "tss_cfg.svh"
module test_thermometer_serial_slave;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic trip = 1'b0;
    logic scl, pull, sda, sda_out, sda_oe, pin_out, pin_oe, conv, nonvolatile_busy_flag, ack;
    logic [7:0] q;
    logic [7:0] got [0:7];
    logic ak [0:7];
    int err_count = 0;
    int n_compared = 0;
    localparam logic [6:0] SLV = 7'h4D; // fixed 1001, pins 101
    // pull-up: the line is low only while a side pulls it
    assign sda = (pull || sda_oe) ? 1'b0 : 1'b1;
    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end
    tss_bus_master m (.scl_out(scl), .pull_out(pull), .sda_in(sda));
    tss_top DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .addr_pin_hi_in(1'b1),
        .addr_pin_mid_in(1'b0), .addr_pin_lo_in(1'b1), .thermostat_trip_in(trip),
        .temperature_in(16'h1234), .programmable_output_pin_out(pin_out),
        .programmable_output_pin_oe_out(pin_oe), .converting_out(conv),
        .nonvolatile_busy_flag_out(nonvolatile_busy_flag));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : cyc
    task automatic head(input logic [7:0] a);
        m.start();
        m.xfer({SLV, 1'b0}, 1'b1, q, ack);
        chk({7'h0, ack}, 8'h00);
        m.xfer(a, 1'b1, q, ack);
        chk({7'h0, ack}, 8'h00);
    endtask : head
    // n=0 sends a bare command byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
        head(a);
        for (int i = 0; i < n; i++) begin
            m.xfer(d + 8'h11 * i[7:0], 1'b1, q, ak[i]);
        end
        m.stop();
    endtask : wr
    task automatic rd(input logic [7:0] a, input int n);
        head(a);
        m.start();
        m.xfer({SLV, 1'b1}, 1'b1, q, ack);
        chk({7'h0, ack}, 8'h00);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hFF, i == n - 1, got[i], ack);
        end
        m.stop();
    endtask : rd
    task automatic t_reset;
        rd(`TSS_ADDR_CFG_MSB, 2);
        chk(got[0], `TSS_CFG_MSB_RESET);
        chk(got[1], 8'hA8);
        @(posedge core_clk_in) trip <= 1'b1;
        cyc(6);
        chk({7'h0, pin_oe}, 8'h01);
        wr(`TSS_ADDR_CFG_LSB, 8'h40, 1);
        cyc(6);
        chk({7'h0, pin_oe}, 8'h01);
        rd(`TSS_ADDR_CFG_LSB, 1);
        chk(got[0], 8'h68);
        @(posedge core_clk_in) trip <= 1'b0;
        wr(`TSS_CMD_SOFT_POR, 8'h00, 0);
        cyc(6);
        chk({7'h0, pin_oe}, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_burst;
        wr(8'hA4, 8'h11, 4);
        rd(8'hA4, 4);
        for (int i = 0; i < 4; i++) begin
            chk(got[i], 8'h11 * (i[7:0] + 8'h01));
        end
        wr(`TSS_ADDR_CFG_LSB, 8'h80, 2);
        chk({7'h0, ak[1]}, 8'h01);
        rd(`TSS_ADDR_CFG_LSB, 2);
        chk(got[1], `TSS_READ_PAST);
        m.start();
        m.xfer(8'h90, 1'b1, q, ack);
        m.stop();
        chk({7'h0, ack}, 8'h01);
        $display("test burst done");
    endtask : t_burst
    task automatic t_conv;
        wr(`TSS_ADDR_CFG_MSB, 8'h00, 1);
        wr(`TSS_CMD_START_CONV, 8'h00, 0);
        cyc(4);
        chk({7'h0, conv}, 8'h01);
        rd(`TSS_ADDR_CFG_MSB, 1);
        chk(got[0] & 8'h80, 8'h00);
        wr(`TSS_CMD_STOP_CONV, 8'h00, 0);
        cyc(4);
        chk({7'h0, conv}, 8'h00);
        wr(`TSS_ADDR_CFG_MSB, 8'h01, 1);
        wr(`TSS_CMD_START_CONV, 8'h00, 0);
        wr(`TSS_CMD_STOP_CONV, 8'h00, 0);
        cyc(4);
        chk({7'h0, conv}, 8'h01);
        wr(`TSS_CMD_SOFT_POR, 8'h00, 0);
        cyc(4);
        chk({7'h0, conv}, 8'h00);
        $display("test conversion done");
    endtask : t_conv
    // copy while converting continuously; the store itself does not wait on conversion state
    task automatic t_nv;
        wr(`TSS_CMD_START_CONV, 8'h00, 0);
        wr(8'hA4, 8'h5A, 1);
        wr(`TSS_CMD_COPY, 8'h00, 0);
        cyc(4);
        chk({7'h0, nonvolatile_busy_flag}, 8'h01);
        for (int i = 0; i < 1200 && nonvolatile_busy_flag === 1'b1; i++) begin
            cyc(1);
        end
        chk({7'h0, nonvolatile_busy_flag}, 8'h00);
        wr(8'hA4, 8'h00, 1);
        wr(`TSS_CMD_RECALL, 8'h00, 0);
        rd(8'hA4, 1);
        chk(got[0], 8'h5A);
        wr(`TSS_CMD_STOP_CONV, 8'h00, 0);
        $display("test storage done");
    endtask : t_nv
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        m.start();
        m.stop();
        cyc(7);
        @(posedge core_clk_in) rst_n_in <= 1'b1;
        cyc(4);
        t_reset();
        t_burst();
        t_conv();
        t_nv();
        tally_and_finish();
    end
    initial begin
        #2_000_000;
        err_count++;
        tally_and_finish();
    end
endmodule : test_thermometer_serial_slave
